// ### bench/dbr_host_model.sv
// dbr_host_model: link master, 48 ns clock only inside frames
// assumes: bench calls its tasks; device pins fed back for capture
`timescale 1ns/1ns
`default_nettype none
module dbr_host_model (
    // device pins seen
    input wire logic [7:0] rd_i,
    input wire logic rd_oe_i,
    input wire logic strobe_i,
    input wire logic strobe_oe_i,
    // host pins
    output logic select_n_o,
    output logic link_clk_o,
    output logic [7:0] dq_o,
    output logic mask_o
);
    // idle pins
    initial begin
        select_n_o = 1'b1;
        link_clk_o = 1'b0;
        dq_o = 8'h00;
        mask_o = 1'b0;
    end
    // select with clock idle
    task automatic open_frame();
        #1 select_n_o = 1'b0;
        #12;
    endtask
    // one edge, byte centred; got answers the previous edge
    task automatic tick(input logic [7:0] b, input logic rel, output logic [10:0] got);
        dq_o = rel ? ~dq_o : b;
        mask_o = ~mask_o;
        #4 got = {strobe_oe_i, rd_oe_i, strobe_i, rd_i};
        #8 link_clk_o = ~link_clk_o;
        #12;
    endtask
    // deselect with clock idle
    task automatic close_frame();
        #12 select_n_o = 1'b1;
        dq_o = ~dq_o;
    endtask
endmodule
`default_nettype wire

// ### bench/dbr_slave_monitor.sv
// dbr_slave_monitor: assertions on bus and link ports
// assumes: bound into dbr_slave, one clock domain
`timescale 1ns/1ns
`default_nettype none
module dbr_slave_monitor (
    // clock, reset, bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // link pins
    input wire logic select_n_i,
    input wire logic link_clk_i,
    input wire logic [7:0] dq_o,
    input wire logic dq_oe_o,
    input wire logic read_write_strobe_o,
    input wire logic read_write_strobe_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // link clock quiet while data is driven
    sequence s_quiet; (dq_oe_o && $stable(link_clk_i))[*8]; endsequence
    // bus and link relations
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_hold; s_quiet |-> $stable(dq_o); endproperty
    a_hold: assert property (p_hold) else $error("data moved with idle clock");
    property p_pair; dq_oe_o |-> read_write_strobe_oe_o; endproperty
    a_pair: assert property (p_pair) else $error("data without strobe");
    property p_toggle;
        dq_oe_o && $past(dq_oe_o) && $changed(dq_o) |-> $changed(read_write_strobe_o);
    endproperty
    a_toggle: assert property (p_toggle) else $error("byte without strobe edge");
    property p_start; $fell(select_n_i) |-> ##[1:8] read_write_strobe_oe_o; endproperty
    a_start: assert property (p_start) else $error("no strobe in command phase");
    property p_end; $rose(select_n_i) |-> ##[1:8] !dq_oe_o && !read_write_strobe_oe_o; endproperty
    a_end: assert property (p_end) else $error("pins still driven after deselect");
    property p_idle; select_n_i[*8] |-> !dq_oe_o; endproperty
    a_idle: assert property (p_idle) else $error("data driven while idle");
endmodule
bind dbr_slave dbr_slave_monitor i_dbr_slave_monitor (.*);
`default_nettype wire

// ### bench/dbr_slave_tb.sv
// dbr_slave_tb: register reads and writes over the link
// assumes: package and design compiled first
`timescale 1ns/1ns
`default_nettype none
module dbr_slave_tb;
    import dbr_pkg::*;
    logic clk_i, rst_i, ack, sel_n, lclk, mask, dq_oe, s_o, s_oe, read_write_strobe;
    logic [7:0] hdq, dq_o, dq_w;
    logic [31:0] rdat;
    dbr_wb_req_t req;
    int errors = 0, compares = 0, cycles = 0;
    // shared pins resolved from enables
    assign dq_w = dq_oe ? dq_o : hdq;
    assign read_write_strobe = s_oe ? s_o : mask;
    dbr_slave i_dbr_slave (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
        .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .select_n_i(sel_n), .link_clk_i(lclk), .dq_i(dq_w),
        .dq_o(dq_o), .dq_oe_o(dq_oe), .read_write_strobe_i(read_write_strobe), .read_write_strobe_o(s_o),
        .read_write_strobe_oe_o(s_oe));
    dbr_host_model i_dbr_host_model (.rd_i(dq_o), .rd_oe_i(dq_oe), .strobe_i(read_write_strobe),
        .strobe_oe_i(s_oe), .select_n_o(sel_n), .link_clk_o(lclk), .dq_o(hdq), .mask_o(mask));
    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // classic cycle held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, a, 4'hf, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask
    // six command bytes, capture taken on the fifth
    task automatic send_ca(input logic [47:0] ca, output logic [10:0] g);
        logic [10:0] t;
        i_dbr_host_model.open_frame();
        for (int i = 5; i >= 0; i--) begin
            i_dbr_host_model.tick(ca[i*8 +: 8], 1'b0, t);
            if (i == 1) g = t;
        end
    endtask
    // control reset value, unmapped place
    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, ADR_CONTROL, 32'h0, q);
        chk(q, {28'h0, LAT_RESET});
        wb(1'b1, 8'h40, 32'hffff, q);
        wb(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0);
    endtask
    // zero latency register write
    task automatic t_reg_write(input logic [15:0] v);
        logic [31:0] q;
        logic [10:0] g;
        send_ca({3'b010, 45'h0}, g);
        i_dbr_host_model.tick(v[15:8], 1'b0, g);
        i_dbr_host_model.tick(v[7:0], 1'b0, g);
        chk(g[10], 1'b0);
        i_dbr_host_model.close_frame();
        wb(1'b0, ADR_REG_WRITE, 32'h0, q);
        chk(q, {16'h0, v});
    endtask
    // register read, with or without extra latency
    task automatic t_reg_read(input logic x);
        logic [31:0] q;
        logic [10:0] g;
        wb(1'b1, ADR_CONTROL, {27'h0, x, LAT_RESET}, q);
        wb(1'b1, ADR_REG_VALUE, 32'h5a3c, q);
        send_ca({3'b110, 45'h0}, g);
        chk(g[10:8], {2'b10, x});
        for (int i = 0; i < 8 * (1 + x); i++) i_dbr_host_model.tick(8'h0, 1'b1, g);
        chk(g[9], 1'b0);
        for (int i = 0; i < 5; i++) begin
            i_dbr_host_model.tick(8'h0, 1'b1, g);
            if (i > 0) begin
                chk(g, {2'b11, i[0], i[0] ? 8'h5a : 8'h3c});
            end
        end
        i_dbr_host_model.close_frame();
        repeat (10) @(posedge clk_i);
        chk(dq_oe, 1'b0);
    endtask
    // main sequence
    initial begin
        req = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_reg_write(16'hc3a5);
        t_reg_read(1'b0);
        t_reg_read(1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### pkg/dbr_pkg.sv
// dbr_pkg: shared constants and types for the ddr bus transaction slave
// assumes: 48-bit command word, 8-bit ddr data pins
package dbr_pkg;

    // --------------------
    // command-address word layout
    // --------------------
    localparam int CA_W = 48;
    localparam int CA_BYTES = 6;
    localparam logic [2:0] CA_LAST_BYTE = 3'h5;
    localparam logic [2:0] CA_ROW_BYTE = 3'h3;   // byte carrying bits 23:16
    localparam int CA_ROW_LO = 16;
    localparam int CA_COL_W = 3;

    // --------------------
    // wishbone register map
    // --------------------
    localparam int WB_ADR_W = 8;
    localparam logic [7:0] ADR_CONTROL = 8'h00;
    localparam logic [7:0] ADR_REG_VALUE = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_REG_WRITE = 8'h0c;

    // control register fields and reset values
    localparam int CTL_LAT_LSB = 0;
    localparam int CTL_LAT_W = 4;
    localparam int CTL_EXTRA_BIT = 4;
    localparam int CTL_WRAP_LSB = 5;
    localparam int CTL_WRAP_W = 2;
    localparam logic [3:0] LAT_RESET = 4'h4;
    localparam logic [15:0] REG_VALUE_RESET = 16'h0000;

    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ROW_BIT = 1;
    localparam int ST_READ_BIT = 2;
    localparam int ST_SPACE_BIT = 3;
    localparam int ST_LINEAR_BIT = 4;

    // wrapped burst lengths in words: base shifted by select field
    localparam int WRAP_BASE_WORDS = 8;
    localparam int LAT_CNT_W = 7;

    // --------------------
    // types
    // --------------------
    typedef enum logic [3:0] {
        DBR_IDLE = 4'b0001,
        DBR_CMD = 4'b0010,
        DBR_LAT = 4'b0100,
        DBR_DATA = 4'b1000
    } dbr_state_t;

    // command-address word seen as fields
    typedef struct packed {
        logic is_read;        // bit 47
        logic reg_space;      // bit 46
        logic linear;         // bit 45, one = linear burst
        logic [44:0] addr;
    } dbr_cmd_t;

    typedef struct packed {
        logic [1:0] wrap_sel;
        logic extra_lat;
        logic [3:0] lat_count;
    } dbr_ctrl_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } dbr_wb_req_t;

endpackage

// ### rtl/dbr_pin_sync.sv
// dbr_pin_sync: three-stage synchroniser with agreement filter per bit
// assumes: inputs asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module dbr_pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // raw pins and filtered result
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] lvl_o,
    output logic [W-1:0] chg_o
);
    generate
        if (W < 1) begin : g_bad
            $error("dbr_pin_sync: width must be positive");
        end
    endgenerate

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic s1_ff, s2_ff, s3_ff, lvl_ff;
            // three flops, first read only by second
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                end else begin
                    s1_ff <= async_i[gi];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                end
            end
            // level follows once second and third agree
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    lvl_ff <= 1'b0;
                end else if (s2_ff == s3_ff) begin
                    lvl_ff <= s3_ff;
                end
            end
            assign lvl_o[gi] = lvl_ff;
            assign chg_o[gi] = (s2_ff == s3_ff) && (s3_ff != lvl_ff);
        end
    endgenerate
endmodule
`default_nettype wire

// ### rtl/dbr_slave.sv
// dbr_slave: device-side transaction logic of a ddr 8-bit dram bus
// assumes: host drives select and link clock
// assumes: wishbone classic master
//
// Overview of operation
// RULE_01 - register space words travel upper byte first, lower byte second.
// RULE_02 - read: upper byte while strobe high, lower byte while strobe low.
// RULE_03 - write: upper byte on rising clock edge, lower byte on falling.
// RULE_04 - host centres write data on clock edges for mid-window sampling.
// RULE_05 - latency writes: high strobe masks a byte, so partial writes work.
// RULE_06 - zero-latency writes store full words; device releases the strobe.
// RULE_07 - host selects with clock idle, then clocks the command words.
// RULE_08 - command bit 47 set marks a read.
// RULE_09 - command bit 46 chooses array space (0) or register space (1).
// RULE_10 - command bit 45 chooses wrapped or linear burst.
// RULE_11 - row and upper column come first; third word picks the word.
// RULE_12 - read array access starts once bits 23 to 16 are captured.
// RULE_13 - device drives strobe in command phase: high asks extra latency.
// RULE_14 - extra latency delays first read data by one more latency count.
// RULE_15 - after latency device toggles strobe, a new byte per transition.
// RULE_16 - read data continues while host clocks with select asserted.
// RULE_17 - host keeps bursts short enough for distributed refresh.
// RULE_18 - wrapped bursts wrap in burst length; linear rolls over array end.
// RULE_19 - select released with clock idle ends the transfer.
// RULE_20 - no free-running clock needed; idle clock with select high is fine.
// RULE_21 - host starts with clock low and deselects between transactions.
// RULE_22 - register read repeats upper then lower register byte each word.
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module dbr_slave #(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dbr_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // link pins
    input wire logic select_n_i,
    input wire logic link_clk_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe_o,
    input wire logic read_write_strobe_i,
    output logic read_write_strobe_o,
    output logic read_write_strobe_oe_o
);
    import dbr_pkg::*;

    generate
        if (ADDR_W < 6 || ADDR_W > 29) begin : g_bad
            $error("dbr_slave: ADDR_W must lie in 6..29");
        end
    endgenerate

    // --------------------
    // decoding helpers
    // --------------------

    // next word address, wrapped inside burst or linear with rollover
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                    input logic linear,
                                                    input logic [1:0] wsel);
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] inc;
        mask = ADDR_W'((WRAP_BASE_WORDS << wsel) - 1);
        inc = a + ADDR_W'(1);
        if (linear) begin
            next_addr = inc;
        end else begin
            next_addr = (a & ~mask) | (inc & mask);
        end
    endfunction

    // word address carried by a command word
    function automatic logic [ADDR_W-1:0] cmd_word_addr(input dbr_cmd_t c);
        logic [31:0] full;
        full = {c.addr[44:CA_ROW_LO], c.addr[CA_COL_W-1:0]};
        cmd_word_addr = full[ADDR_W-1:0];
    endfunction

    // --------------------
    // pin synchronisers
    // --------------------
    localparam int SYNC_W = 11;
    logic [SYNC_W-1:0] pin_lvl, pin_chg;
    logic ck_edge, sel_n_lvl, sel_n_chg, mask_lvl;
    logic [7:0] dq_lvl;

    dbr_pin_sync #(.W(SYNC_W)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({dq_i, read_write_strobe_i, select_n_i, link_clk_i}),
        .lvl_o(pin_lvl),
        .chg_o(pin_chg)
    );

    assign ck_edge = pin_chg[0];
    assign sel_n_lvl = pin_lvl[1];
    assign sel_n_chg = pin_chg[1];
    assign mask_lvl = pin_lvl[2];
    assign dq_lvl = pin_lvl[10:3];

    // --------------------
    // wishbone register file
    // --------------------
    dbr_wb_req_t req;
    dbr_ctrl_t ctrl_ff;
    logic [15:0] reg_value_ff;
    logic [15:0] reg_write_ff;
    logic [31:0] status;
    logic ack_ff;
    logic [31:0] dat_o_ff;
    logic wb_write;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                   sel: wb_sel_i, dat: wb_dat_i};
    // write lands at the edge where ack is seen high
    assign wb_write = req.cyc && req.stb && req.we && ack_ff;

    // ack one cycle after request, dropped the following cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req.cyc && req.stb && !ack_ff;
        end
    end

    // read data captured as ack rises; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o_ff <= 32'h0000_0000;
        end else if (req.cyc && req.stb && !ack_ff) begin
            case (req.adr)
                ADR_CONTROL: dat_o_ff <= 32'({ctrl_ff.wrap_sel, ctrl_ff.extra_lat,
                                              ctrl_ff.lat_count});
                ADR_REG_VALUE: dat_o_ff <= {16'h0000, reg_value_ff};
                ADR_STATUS: dat_o_ff <= status;
                ADR_REG_WRITE: dat_o_ff <= {16'h0000, reg_write_ff};
                default: dat_o_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_o_ff;

    // control register, low byte lane only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= '{wrap_sel: 2'h0, extra_lat: 1'b0, lat_count: LAT_RESET};
        end else if (wb_write && req.adr == ADR_CONTROL && req.sel[0]) begin
            ctrl_ff.lat_count <= req.dat[CTL_LAT_LSB +: CTL_LAT_W];
            ctrl_ff.extra_lat <= req.dat[CTL_EXTRA_BIT];
            ctrl_ff.wrap_sel <= req.dat[CTL_WRAP_LSB +: CTL_WRAP_W];
        end
    end

    // value served on register-space reads, byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_value_ff <= REG_VALUE_RESET;
        end else if (wb_write && req.adr == ADR_REG_VALUE) begin
            for (int b = 0; b < 2; b++) begin
                if (req.sel[b]) begin
                    reg_value_ff[b*8 +: 8] <= req.dat[b*8 +: 8];
                end
            end
        end
    end

    // --------------------
    // link transaction engine
    // --------------------
    dbr_state_t state_ff;
    logic [39:0] ca_ff;
    dbr_cmd_t cmd_ff, cmd_now;
    logic [2:0] byte_cnt_ff;
    logic [LAT_CNT_W-1:0] lat_cnt_ff, lat_target_ff;
    logic half_ff;
    logic zero_lat_ff;
    logic row_open_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [7:0] hi_byte_ff;
    logic hi_keep_ff;
    logic [15:0] mem_rd, read_word;
    logic mem_we;
    logic [1:0] mem_be;
    logic deselect;
    logic [LAT_CNT_W-1:0] lat_edges;

    assign cmd_now = dbr_cmd_t'({ca_ff, dq_lvl});
    assign deselect = sel_n_chg && !sel_n_lvl;
    // latency counted in link edges, doubled when extra latency asked
    assign lat_edges = ctrl_ff.extra_lat ? LAT_CNT_W'({ctrl_ff.lat_count, 2'b00})
                                         : LAT_CNT_W'({ctrl_ff.lat_count, 1'b0}); // RULE_14

    // transaction state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= DBR_IDLE;
        end else begin
            case (state_ff)
                DBR_IDLE: begin
                    // select falling: change seen while old level still high
                    if (sel_n_chg && sel_n_lvl) begin
                        state_ff <= DBR_CMD;
                    end
                end
                DBR_CMD: begin
                    if (sel_n_lvl) begin
                        state_ff <= DBR_IDLE; // RULE_19
                    end else if (ck_edge && byte_cnt_ff == CA_LAST_BYTE) begin
                        if (!cmd_now.is_read && cmd_now.reg_space) begin
                            state_ff <= DBR_DATA; // RULE_06
                        end else if (lat_edges == '0) begin
                            state_ff <= DBR_DATA;
                        end else begin
                            state_ff <= DBR_LAT;
                        end
                    end
                end
                DBR_LAT: begin
                    if (sel_n_lvl) begin
                        state_ff <= DBR_IDLE; // RULE_19
                    end else if (ck_edge && lat_cnt_ff == lat_target_ff - 1'b1) begin
                        state_ff <= DBR_DATA;
                    end
                end
                DBR_DATA: begin
                    if (sel_n_lvl) begin
                        state_ff <= DBR_IDLE; // RULE_19 RULE_20
                    end
                end
                default: state_ff <= DBR_IDLE;
            endcase
        end
    end

    // command-address capture, one byte per link edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ca_ff <= '0;
            byte_cnt_ff <= 3'h0;
            cmd_ff <= '0;
            zero_lat_ff <= 1'b0;
            lat_target_ff <= '0;
        end else if (state_ff == DBR_IDLE) begin
            byte_cnt_ff <= 3'h0;
        end else if (state_ff == DBR_CMD && ck_edge) begin
            ca_ff <= {ca_ff[31:0], dq_lvl};
            byte_cnt_ff <= byte_cnt_ff + 3'h1;
            if (byte_cnt_ff == CA_LAST_BYTE) begin
                cmd_ff <= cmd_now; // RULE_08 RULE_09 RULE_10
                zero_lat_ff <= !cmd_now.is_read && cmd_now.reg_space;
                lat_target_ff <= lat_edges;
            end
        end
    end

    // array access opens once bits 23:16 are in
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            row_open_ff <= 1'b0;
        end else if (state_ff == DBR_IDLE) begin
            row_open_ff <= 1'b0;
        end else if (state_ff == DBR_CMD && ck_edge && byte_cnt_ff == CA_ROW_BYTE) begin
            row_open_ff <= 1'b1; // RULE_12 RULE_11
        end
    end

    // latency edge counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_cnt_ff <= '0;
        end else if (state_ff != DBR_LAT) begin
            lat_cnt_ff <= '0;
        end else if (ck_edge) begin
            lat_cnt_ff <= lat_cnt_ff + 1'b1; // RULE_13
        end
    end

    // word address: loaded from command, advanced per word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_ff <= '0;
        end else if (state_ff == DBR_CMD && ck_edge && byte_cnt_ff == CA_LAST_BYTE) begin
            addr_ff <= cmd_word_addr(cmd_now); // RULE_11
        end else if (state_ff == DBR_DATA && ck_edge && half_ff) begin
            addr_ff <= next_addr(addr_ff, cmd_ff.linear, ctrl_ff.wrap_sel); // RULE_18
        end
    end

    // byte half within a word, upper byte first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half_ff <= 1'b0;
        end else if (state_ff != DBR_DATA) begin
            half_ff <= 1'b0;
        end else if (ck_edge) begin
            half_ff <= !half_ff; // RULE_01
        end
    end

    // --------------------
    // read data path
    // --------------------

    // register space repeats the same word every cycle
    assign read_word = cmd_ff.reg_space ? reg_value_ff : mem_rd; // RULE_22

    // strobe and data pins for reads and the command phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_o <= 8'h00;
            dq_oe_o <= 1'b0;
            read_write_strobe_o <= 1'b0;
            read_write_strobe_oe_o <= 1'b0;
        end else begin
            case (state_ff)
                DBR_IDLE: begin
                    dq_oe_o <= 1'b0;
                    read_write_strobe_o <= ctrl_ff.extra_lat; // RULE_13
                    read_write_strobe_oe_o <= sel_n_chg && sel_n_lvl;
                end
                DBR_CMD: begin
                    if (sel_n_lvl) begin
                        read_write_strobe_oe_o <= 1'b0;
                    end else if (ck_edge && byte_cnt_ff == CA_LAST_BYTE) begin
                        read_write_strobe_o <= 1'b0;
                        read_write_strobe_oe_o <= cmd_now.is_read; // RULE_06
                    end
                end
                DBR_LAT: begin
                    if (sel_n_lvl) begin
                        read_write_strobe_oe_o <= 1'b0;
                    end
                end
                DBR_DATA: begin
                    if (deselect || sel_n_lvl) begin
                        dq_oe_o <= 1'b0; // RULE_19
                        read_write_strobe_oe_o <= 1'b0;
                    end else if (ck_edge && cmd_ff.is_read) begin
                        dq_oe_o <= 1'b1; // RULE_15 RULE_16
                        if (!half_ff) begin
                            dq_o <= read_word[15:8]; // RULE_02
                            read_write_strobe_o <= 1'b1;
                        end else begin
                            dq_o <= read_word[7:0]; // RULE_02
                            read_write_strobe_o <= 1'b0;
                        end
                    end
                end
                default: begin
                    dq_oe_o <= 1'b0;
                    read_write_strobe_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // --------------------
    // write data path
    // --------------------

    // upper byte held until its partner arrives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hi_byte_ff <= 8'h00;
            hi_keep_ff <= 1'b0;
        end else if (state_ff == DBR_DATA && ck_edge && !half_ff && !cmd_ff.is_read) begin
            hi_byte_ff <= dq_lvl; // RULE_03
            hi_keep_ff <= zero_lat_ff || !mask_lvl; // RULE_05
        end
    end

    // word completes on the lower-byte edge
    assign mem_we = state_ff == DBR_DATA && ck_edge && half_ff && !cmd_ff.is_read
                    && !cmd_ff.reg_space;
    assign mem_be = zero_lat_ff ? 2'b11 : {hi_keep_ff, !mask_lvl}; // RULE_05 RULE_06

    // register-space write keeps the full word, no masking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_write_ff <= 16'h0000;
        end else if (state_ff == DBR_DATA && ck_edge && half_ff && !cmd_ff.is_read
                     && cmd_ff.reg_space) begin
            reg_write_ff <= {hi_byte_ff, dq_lvl}; // RULE_01 RULE_06
        end
    end

    dbr_word_mem #(.ADDR_W(ADDR_W)) u_mem (
        .clk_i(clk_i),
        .wr_en_i(mem_we),
        .wr_addr_i(addr_ff),
        .wr_data_i({hi_byte_ff, dq_lvl}),
        .wr_be_i(mem_be),
        .rd_addr_i(addr_ff),
        .rd_data_o(mem_rd)
    );

    // --------------------
    // status
    // --------------------
    always_comb begin
        status = 32'h0000_0000;
        status[ST_BUSY_BIT] = state_ff != DBR_IDLE;
        status[ST_ROW_BIT] = row_open_ff;
        status[ST_READ_BIT] = cmd_ff.is_read;
        status[ST_SPACE_BIT] = cmd_ff.reg_space;
        status[ST_LINEAR_BIT] = cmd_ff.linear;
    end
endmodule
`default_nettype wire

// ### rtl/dbr_word_mem.sv
// dbr_word_mem: 16-bit word array with byte enables
// assumes: one write port on clk_i, combinational read port
`timescale 1ns/1ns
`default_nettype none
module dbr_word_mem #(
    parameter int ADDR_W = 10
) (
    // clock
    input wire logic clk_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [1:0] wr_be_i,
    // read port
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [15:0] rd_data_o
);
    logic [15:0] mem [0:(1<<ADDR_W)-1];

    // byte-lane write, masked lanes keep old contents
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < 2; b++) begin
            if (wr_en_i && wr_be_i[b]) begin
                mem[wr_addr_i][b*8 +: 8] <= wr_data_i[b*8 +: 8];
            end
        end
    end

    assign rd_data_o = mem[rd_addr_i];
endmodule
`default_nettype wire
